// [logic/interrupt_status_collector.sv]
// interrupt_status_collector: interrupt status and enable registers of
// the network controller, sticky event flags and the master indication.
// assumes: host register port synchronous to mclk; event inputs are
// one-cycle pulses or levels synchronous to mclk.
//
// Overview of operation
// [R1] writing one clears a clearable flag; writing zero leaves it
// [R2] software trigger flag bit 31 sets while its enable is high
// [R3] bit 25 sets when stop requested and transmitter halted
// [R4] bit 24 sets when the receiver halts
// [R5] bit 23 sets when drop counter steps 7FFFFFFh to 8000000h
// [R6] bit 21 sets when a notify-marked buffer finished loading
// [R7] bit 20 sets when programmed receive DMA count has been moved
// [R8] bit 19 sets when timer wraps from zero to FFFFh
// [R9] bit 18 is read-only transceiver event level, writes ignored
// [R10] bit 17 sets on power event regardless of the power pin
// [R11] only a write to byte test register wakes the device
// [R12] no deassertion delay applies to the power event interrupt
// [R13] bit 16 sets on transmit status FIFO overflow
// [R14] bit 15 sets when a received packet exceeds 2048 bytes
// [R15] bit 14 on receiver error, bit 13 on transmitter error
// [R16] bit 10 sets on write attempt to a full transmit data FIFO
// [R17] bit 9 sets while transmit free space exceeds threshold
// [R18] bit 8 on transmit status full, bit 4 on receive status full
// [R19] bit 7 and bit 3 set at transmit and receive status levels
// [R20] bit 6 sets whenever a received frame is dropped
// [R21] bits 2-0 are per-pin I/O flags, cleared by writing one
// [R22] flags record events whatever the enable mask holds
// [R23] enable bit one makes the flag drive the master request
// [R24] master indication high whenever any enabled flag is active
// [R25] status level holds when used words exceed the threshold
// [R26] flags stay set until cleared and are zero after reset
// [R27] an event in the clearing cycle leaves the flag set
`timescale 1ns/1ps
module interrupt_status_collector
(
    input  wire logic                              mclk,
    input  wire logic                              rst_n,
    // host register port
    input  wire logic [isc_pkg::ISC_ADDR_W-1:0]    reg_addr,
    input  wire logic                              reg_wr,
    input  wire logic                              reg_rd,
    input  wire logic [isc_pkg::ISC_DATA_W-1:0]    reg_wdata,
    output logic      [isc_pkg::ISC_DATA_W-1:0]    reg_rdata,
    // transmit side events
    input  wire logic                              tx_stop_request,
    input  wire logic                              tx_halted,
    input  wire logic                              tx_buffer_loaded,
    input  wire logic                              completion_notify_marker,
    input  wire logic                              tx_status_overflow,
    input  wire logic                              tx_error,
    input  wire logic                              tx_data_write_when_full,
    input  wire logic [isc_pkg::ISC_LEVEL_W-1:0]   tx_free_blocks,
    input  wire logic [isc_pkg::ISC_LEVEL_W-1:0]   tx_space_threshold,
    input  wire logic                              tx_status_full,
    input  wire logic [isc_pkg::ISC_LEVEL_W-1:0]   tx_status_used,
    input  wire logic [isc_pkg::ISC_LEVEL_W-1:0]   tx_status_threshold,
    // receive side events
    input  wire logic                              rx_halted,
    input  wire logic [isc_pkg::ISC_DROP_CNT_W-1:0] rx_drop_count,
    input  wire logic                              rx_dma_start,
    input  wire logic [isc_pkg::ISC_DMA_CNT_W-1:0] receive_dma_count,
    input  wire logic                              rx_word_moved,
    input  wire logic                              rx_frame_end,
    input  wire logic [isc_pkg::ISC_FRAME_LEN_W-1:0] rx_frame_len,
    input  wire logic                              rx_error,
    input  wire logic                              rx_frame_dropped,
    input  wire logic                              rx_status_full,
    input  wire logic [isc_pkg::ISC_LEVEL_W-1:0]   rx_status_used,
    input  wire logic [isc_pkg::ISC_LEVEL_W-1:0]   rx_status_threshold,
    // miscellaneous sources
    input  wire logic [isc_pkg::ISC_TIMER_W-1:0]   timer_value,
    input  wire logic                              transceiver_event,
    input  wire logic                              power_event,
    input  wire logic [isc_pkg::ISC_IO_PINS-1:0]   io_pin_events,
    // results
    output logic                                   master_irq,
    output logic                                   power_event_irq,
    output logic                                   wake_request
);
    import isc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // register decode

    logic                  status_write;
    logic                  enable_write;
    logic                  byte_test_write;
    logic [ISC_DATA_W-1:0] interrupt_enable;
    logic [ISC_DATA_W-1:0] interrupt_status;
    logic                  software_trigger_enable;

    assign status_write    = reg_wr && (reg_addr == ISC_OFS_STATUS);
    assign enable_write    = reg_wr && (reg_addr == ISC_OFS_ENABLE);
    assign byte_test_write = reg_wr && (reg_addr == ISC_OFS_BYTE_TEST);

    assign software_trigger_enable = interrupt_enable[ISC_BIT_SW_TRIGGER];

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            interrupt_enable <= ISC_ENABLE_RESET;
        else if (enable_write)
            interrupt_enable <= reg_wdata & ISC_ENABLE_MASK; // R23
    end

    ////////////////////////////////////////////////////////////////////////
    // derived event conditions

    logic                     drop_halfway;
    logic                     timer_wrapped;
    logic [ISC_DMA_CNT_W-1:0] dma_moved;
    logic                     dma_active;
    logic                     dma_done;
    logic                     rx_watchdog;

    isc_step_detect
    #(
        .WIDTH (ISC_DROP_CNT_W)
    )
    u_drop_halfway
    (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .value      (rx_drop_count),
        .from_value (ISC_DROP_BEFORE_HALF),
        .to_value   (ISC_DROP_AT_HALF),
        .stepped    (drop_halfway)
    ); // R5

    isc_step_detect
    #(
        .WIDTH (ISC_TIMER_W)
    )
    u_timer_wrap
    (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .value      (timer_value),
        .from_value (ISC_TIMER_ZERO),
        .to_value   (ISC_TIMER_WRAPPED),
        .stepped    (timer_wrapped)
    ); // R8

    // counts words leaving the receive FIFO against the programmed count
    assign dma_done = dma_active && rx_word_moved
                      && ((dma_moved + ISC_DMA_CNT_ONE) == receive_dma_count);

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dma_moved  <= ISC_DMA_CNT_RESET;
            dma_active <= 1'b0;
        end
        else if (rx_dma_start)
        begin
            dma_moved  <= ISC_DMA_CNT_RESET;
            dma_active <= (receive_dma_count != ISC_DMA_CNT_RESET);
        end
        else if (dma_done)
        begin
            dma_moved  <= ISC_DMA_CNT_RESET; // R7
            dma_active <= 1'b0;
        end
        else if (dma_active && rx_word_moved)
            dma_moved  <= dma_moved + ISC_DMA_CNT_ONE;
    end

    assign rx_watchdog = rx_frame_end
                         && (rx_frame_len > ISC_RX_WATCHDOG_LEN); // R14

    ////////////////////////////////////////////////////////////////////////
    // sticky flag bank

    isc_flag_if flags ();

    logic [ISC_DATA_W-1:0] next_set;

    // sources are gathered without regard to the enable mask
    always_comb
    begin
        next_set = '0; // R22
        next_set[ISC_BIT_SW_TRIGGER]      = software_trigger_enable; // R2
        next_set[ISC_BIT_TX_HALTED]       = tx_stop_request
                                            && tx_halted; // R3
        next_set[ISC_BIT_RX_HALTED]       = rx_halted; // R4
        next_set[ISC_BIT_DROP_HALFWAY]    = drop_halfway; // R5
        next_set[ISC_BIT_TX_BUF_DONE]     = tx_buffer_loaded
                                            && completion_notify_marker; // R6
        next_set[ISC_BIT_RX_DMA]          = dma_done; // R7
        next_set[ISC_BIT_TIMER_WRAP]      = timer_wrapped; // R8
        next_set[ISC_BIT_POWER_EVENT]     = power_event; // R10
        next_set[ISC_BIT_TX_STS_OVERFLOW] = tx_status_overflow; // R13
        next_set[ISC_BIT_RX_WATCHDOG]     = rx_watchdog; // R14
        next_set[ISC_BIT_RX_ERROR]        = rx_error; // R15
        next_set[ISC_BIT_TX_ERROR]        = tx_error; // R15
        next_set[ISC_BIT_TX_DATA_OVERRUN] = tx_data_write_when_full; // R16
        next_set[ISC_BIT_TX_DATA_SPACE]   = tx_free_blocks
                                            > tx_space_threshold; // R17
        next_set[ISC_BIT_TX_STS_FULL]     = tx_status_full; // R18
        next_set[ISC_BIT_RX_STS_FULL]     = rx_status_full; // R18
        next_set[ISC_BIT_TX_STS_LEVEL]    = tx_status_used
                                            > tx_status_threshold; // R19 R25
        next_set[ISC_BIT_RX_STS_LEVEL]    = rx_status_used
                                            > rx_status_threshold; // R19 R25
        next_set[ISC_BIT_FRAME_DROPPED]   = rx_frame_dropped; // R20
        next_set[ISC_BIT_IO_PIN_LSB +: ISC_IO_PINS] = io_pin_events; // R21
    end

    assign flags.set = next_set & ISC_CLEARABLE_MASK;
    assign flags.clr = status_write ? (reg_wdata & ISC_CLEARABLE_MASK)
                                    : '0; // R1 R21

    isc_sticky_bank u_flags
    (
        .mclk  (mclk),
        .rst_n (rst_n),
        .flags (flags.bank)
    );

    ////////////////////////////////////////////////////////////////////////
    // status view, read data and outputs

    // transceiver bit follows its source and has no storage to clear
    always_comb
    begin
        interrupt_status = flags.q & ISC_CLEARABLE_MASK;
        interrupt_status[ISC_BIT_TRANSCEIVER] = transceiver_event; // R9
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= ISC_RDATA_RESET;
        else if (reg_rd)
        begin
            case (reg_addr)
                ISC_OFS_STATUS: reg_rdata <= interrupt_status;
                ISC_OFS_ENABLE: reg_rdata <= interrupt_enable;
                default:        reg_rdata <= ISC_RDATA_RESET;
            endcase
        end
    end

    // combined request, free of any pin enable or deassertion interval
    assign master_irq = |(interrupt_status & interrupt_enable); // R23 R24

    // power event path bypasses any hold-off
    assign power_event_irq = interrupt_status[ISC_BIT_POWER_EVENT]
                             && interrupt_enable[ISC_BIT_POWER_EVENT]; // R12

    // a detected power event never wakes the device on its own
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            wake_request <= 1'b0;
        else
            wake_request <= byte_test_write; // R11
    end

endmodule // interrupt_status_collector

// [shared/isc_pkg.sv]
// isc_pkg: offsets, field positions, reset values and limits shared by
// the interrupt status collector and its helper modules.
// assumes: byte addresses on the host register port, 32-bit data words.
package isc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register map
    localparam int          ISC_ADDR_W            = 8;
    localparam int          ISC_DATA_W            = 32;
    localparam logic [7:0]  ISC_OFS_STATUS        = 8'h58;
    localparam logic [7:0]  ISC_OFS_ENABLE        = 8'h5C;
    localparam logic [7:0]  ISC_OFS_BYTE_TEST     = 8'h64;
    localparam logic [31:0] ISC_STATUS_RESET      = 32'h0000_0000;
    localparam logic [31:0] ISC_ENABLE_RESET      = 32'h0000_0000;
    localparam logic [31:0] ISC_RDATA_RESET       = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // status and enable bit positions
    localparam int ISC_BIT_SW_TRIGGER      = 31;
    localparam int ISC_BIT_TX_HALTED       = 25;
    localparam int ISC_BIT_RX_HALTED       = 24;
    localparam int ISC_BIT_DROP_HALFWAY    = 23;
    localparam int ISC_BIT_TX_BUF_DONE     = 21;
    localparam int ISC_BIT_RX_DMA          = 20;
    localparam int ISC_BIT_TIMER_WRAP      = 19;
    localparam int ISC_BIT_TRANSCEIVER     = 18;
    localparam int ISC_BIT_POWER_EVENT     = 17;
    localparam int ISC_BIT_TX_STS_OVERFLOW = 16;
    localparam int ISC_BIT_RX_WATCHDOG     = 15;
    localparam int ISC_BIT_RX_ERROR        = 14;
    localparam int ISC_BIT_TX_ERROR        = 13;
    localparam int ISC_BIT_TX_DATA_OVERRUN = 10;
    localparam int ISC_BIT_TX_DATA_SPACE   = 9;
    localparam int ISC_BIT_TX_STS_FULL     = 8;
    localparam int ISC_BIT_TX_STS_LEVEL    = 7;
    localparam int ISC_BIT_FRAME_DROPPED   = 6;
    localparam int ISC_BIT_RX_STS_FULL     = 4;
    localparam int ISC_BIT_RX_STS_LEVEL    = 3;
    localparam int ISC_BIT_IO_PIN_LSB      = 0;
    localparam int ISC_IO_PINS             = 3;

    // flags cleared by a write of one (bit 18 excluded: read-only level)
    localparam logic [31:0] ISC_CLEARABLE_MASK    = 32'h83BB_E7DF;
    // bits that exist in the enable register
    localparam logic [31:0] ISC_ENABLE_MASK       = 32'h83BF_E7DF;

    ////////////////////////////////////////////////////////////////////////
    // event thresholds and widths
    localparam int           ISC_DROP_CNT_W       = 28;
    localparam logic [27:0]  ISC_DROP_BEFORE_HALF = 28'h7FF_FFFF;
    localparam logic [27:0]  ISC_DROP_AT_HALF     = 28'h800_0000;
    localparam int           ISC_TIMER_W          = 16;
    localparam logic [15:0]  ISC_TIMER_ZERO       = 16'h0000;
    localparam logic [15:0]  ISC_TIMER_WRAPPED    = 16'hFFFF;
    localparam int           ISC_FRAME_LEN_W      = 16;
    localparam logic [15:0]  ISC_RX_WATCHDOG_LEN  = 16'h0800;
    localparam int           ISC_DMA_CNT_W        = 12;
    localparam logic [11:0]  ISC_DMA_CNT_RESET    = 12'h000;
    localparam logic [11:0]  ISC_DMA_CNT_ONE      = 12'h001;
    localparam int           ISC_LEVEL_W          = 8;

endpackage : isc_pkg

// [shared/isc_flag_if.sv]
// isc_flag_if: set, clear and state of a bank of sticky flags, carried
// between the collector and its flag bank.
// assumes: set and clear are one-cycle qualified by the collector.
`timescale 1ns/1ps
interface isc_flag_if;
    import isc_pkg::*;

    logic [ISC_DATA_W-1:0] set;
    logic [ISC_DATA_W-1:0] clr;
    logic [ISC_DATA_W-1:0] q;

    modport ctrl
    (
        output set,
        output clr,
        input  q
    );

    modport bank
    (
        input  set,
        input  clr,
        output q
    );

endinterface : isc_flag_if

// [logic/isc_sticky_bank.sv]
// isc_sticky_bank: a word of sticky flags, set by hardware, cleared by
// writing one; a set in the clearing cycle wins.
// assumes: mclk, asynchronous active-low rst_n.
`timescale 1ns/1ps
module isc_sticky_bank
(
    input  wire logic mclk,
    input  wire logic rst_n,
    isc_flag_if.bank  flags
);
    import isc_pkg::*;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            flags.q <= ISC_STATUS_RESET; // R26
        else
            flags.q <= (flags.q & ~flags.clr) | flags.set; // R1 R26 R27
    end

endmodule // isc_sticky_bank

// [logic/isc_step_detect.sv]
// isc_step_detect: pulses, unregistered, in the same cycle that a value steps from one given
// value straight to another.
// assumes: mclk, asynchronous active-low rst_n; value is synchronous.
`timescale 1ns/1ps
module isc_step_detect
#(
    parameter int WIDTH = 16
)
(
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] value,
    input  wire logic [WIDTH-1:0] from_value,
    input  wire logic [WIDTH-1:0] to_value,
    output logic                  stepped
);

    logic [WIDTH-1:0] last_value;
    logic             last_valid;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            last_value <= '0;
            last_valid <= 1'b0;
        end
        else
        begin
            last_value <= value;
            last_valid <= 1'b1;
        end
    end

    assign stepped = last_valid && (last_value == from_value)
                     && (value == to_value);

endmodule // isc_step_detect

// [verif/isc_monitor.sv]
// isc_monitor: port-level checks of the interrupt status collector.
// assumes: bound to interrupt_status_collector, single clock domain.
`timescale 1ns/1ps
module isc_monitor
(
    input wire logic                                mclk,
    input wire logic                                rst_n,
    input wire logic [isc_pkg::ISC_ADDR_W-1:0]      reg_addr,
    input wire logic                                reg_wr,
    input wire logic                                reg_rd,
    input wire logic [isc_pkg::ISC_DATA_W-1:0]      reg_rdata,
    input wire logic                                rx_frame_end,
    input wire logic [isc_pkg::ISC_FRAME_LEN_W-1:0] rx_frame_len,
    input wire logic                                rx_frame_dropped,
    input wire logic [isc_pkg::ISC_LEVEL_W-1:0]     tx_status_used,
    input wire logic [isc_pkg::ISC_LEVEL_W-1:0]     tx_status_threshold,
    input wire logic [isc_pkg::ISC_TIMER_W-1:0]     timer_value,
    input wire logic                                transceiver_event,
    input wire logic                                power_event,
    input wire logic                                master_irq,
    input wire logic                                power_event_irq,
    input wire logic                                wake_request
);
    import isc_pkg::*;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence rd_sts;
        reg_rd && reg_addr == ISC_OFS_STATUS;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    a_wake_on_write: assert property (
        (reg_wr && reg_addr == ISC_OFS_BYTE_TEST) |=> wake_request)
        else $error("no wake request after byte test write");
    a_wake_has_cause: assert property (
        wake_request |-> $past(reg_wr) &&
        $past(reg_addr) == ISC_OFS_BYTE_TEST)
        else $error("wake request without byte test write");
    a_power_in_master: assert property (
        power_event_irq |-> master_irq)
        else $error("power interrupt not in master indication");
    a_transceiver_shown: assert property (
        rd_sts |=> reg_rdata[ISC_BIT_TRANSCEIVER] == $past(transceiver_event))
        else $error("transceiver bit differs from its source");
    a_watchdog_flag_set: assert property (
        (rx_frame_end && rx_frame_len > ISC_RX_WATCHDOG_LEN) ##1 rd_sts
        |=> reg_rdata[ISC_BIT_RX_WATCHDOG])
        else $error("long frame did not set watchdog flag");
    a_power_flag_set: assert property (
        power_event ##1 rd_sts |=> reg_rdata[ISC_BIT_POWER_EVENT])
        else $error("power event did not set its flag");
    a_drop_flag_set: assert property (
        rx_frame_dropped ##1 rd_sts |=> reg_rdata[ISC_BIT_FRAME_DROPPED])
        else $error("dropped frame did not set its flag");
    a_level_flag_set: assert property (
        (tx_status_used > tx_status_threshold) ##1 rd_sts
        |=> reg_rdata[ISC_BIT_TX_STS_LEVEL])
        else $error("status level did not set its flag");
    a_timer_wrap_set: assert property (
        ($past(rst_n) && timer_value == ISC_TIMER_WRAPPED &&
        $past(timer_value) == ISC_TIMER_ZERO) ##1 rd_sts
        |=> reg_rdata[ISC_BIT_TIMER_WRAP])
        else $error("timer wrap did not set its flag");

    c_wake: cover property (wake_request);
    c_power_irq: cover property (power_event_irq);
    c_master: cover property (master_irq ##1 !master_irq);
endmodule // isc_monitor

bind interrupt_status_collector isc_monitor i_isc_monitor
(
    .mclk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_rdata,
    .rx_frame_end, .rx_frame_len, .rx_frame_dropped, .tx_status_used,
    .tx_status_threshold, .timer_value, .transceiver_event, .power_event,
    .master_irq, .power_event_irq, .wake_request
);

// [verif/isc_host_model.sv]
// isc_host_model: host processor issuing register reads and writes.
// assumes: strobes sampled on rising mclk, read data one cycle later.
`timescale 1ns/1ps
module isc_host_model
(
    input  wire logic [isc_pkg::ISC_DATA_W-1:0] reg_rdata,
    input  wire logic                           mclk,
    output logic      [isc_pkg::ISC_ADDR_W-1:0] reg_addr,
    output logic                                reg_wr,
    output logic                                reg_rd,
    output logic      [isc_pkg::ISC_DATA_W-1:0] reg_wdata
);
    import isc_pkg::*;

    // idle cycles inserted before each access, to act as a slow host
    int gap = 0;

    initial
    begin
        reg_addr = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = '0;
    end

    // a released bus shows the inverse of the last value, not a hold
    task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
        repeat (gap) @(posedge mclk);
        @(posedge mclk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge mclk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
        repeat (gap) @(posedge mclk);
        @(posedge mclk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge mclk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
endmodule // isc_host_model

// [verif/test_interrupt_status_collector.sv]
// test_interrupt_status_collector: register-level tests of the collector.
// assumes: isc_host_model drives the register port; bench drives events.
`timescale 1ns/1ps
module test_interrupt_status_collector;
    import isc_pkg::*;

    localparam logic [7:0] STS = ISC_OFS_STATUS;
    localparam logic [7:0] ENA = ISC_OFS_ENABLE;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic [31:0] ev = '0;
    logic        stp = 1'b0;
    logic        mrk = 1'b0;
    logic        xcv = 1'b0;
    logic [7:0]  lu = '0;
    logic [7:0]  lt = '0;
    logic [27:0] drp = '0;
    logic [11:0] cnt = '0;
    logic [15:0] len = '0;
    logic [15:0] tmr = 16'h0001;
    logic        master_irq;
    logic        power_event_irq;
    logic        wake_request;
    int          err_count = 0;
    int          num_checks = 0;
    int          bits[14] = '{25, 24, 21, 17, 16, 14, 13, 10, 8, 6, 4, 2, 1, 0};

    always #12.5 mclk = ~mclk;

    interrupt_status_collector i_interrupt_status_collector
    (
        .mclk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .tx_stop_request(stp), .tx_halted(ev[25]),
        .tx_buffer_loaded(ev[21]), .completion_notify_marker(mrk),
        .tx_status_overflow(ev[16]), .tx_error(ev[13]),
        .tx_data_write_when_full(ev[10]), .tx_free_blocks(lu),
        .tx_space_threshold(lt), .tx_status_full(ev[8]),
        .tx_status_used(lu), .tx_status_threshold(lt),
        .rx_halted(ev[24]), .rx_drop_count(drp), .rx_dma_start(ev[20]),
        .receive_dma_count(cnt), .rx_word_moved(ev[22]),
        .rx_frame_end(ev[15]), .rx_frame_len(len), .rx_error(ev[14]),
        .rx_frame_dropped(ev[6]), .rx_status_full(ev[4]),
        .rx_status_used(lu), .rx_status_threshold(lt),
        .timer_value(tmr), .transceiver_event(xcv),
        .power_event(ev[17]), .io_pin_events(ev[2:0]),
        .master_irq, .power_event_irq, .wake_request
    );

    isc_host_model i_isc_host_model
    (
        .reg_rdata, .mclk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one clock, then every event pulse is dropped
    task automatic cyc;
        @(posedge mclk);
        #1 ev = '0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        fork
            i_isc_host_model.read_reg(a, d);
            cyc;
        join
        chk(d, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_isc_host_model.write_reg(a, d);
    endtask

    task automatic wrap_up;
        if (err_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        repeat (4000) @(posedge mclk);
        err_count++;
        wrap_up;
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge mclk);
        #1 rst_n = 1'b1;
        rdc(STS, 32'h0);
        rdc(ENA, 32'h0);
        rdc(8'h60, 32'h0);
        stp = 1'b1;
        mrk = 1'b1;
        foreach (bits[i])
        begin
            ev[bits[i]] = 1'b1;
            rdc(STS, 32'h1 << bits[i]);
            wr(STS, ~(32'h1 << bits[i]));
            rdc(STS, 32'h1 << bits[i]);
            wr(STS, 32'h1 << bits[i]);
            rdc(STS, 32'h0);
        end
        chk(master_irq, 1'b0);
        stp = 1'b0;
        mrk = 1'b0;
        ev[25] = 1'b1;
        ev[21] = 1'b1;
        rdc(STS, 32'h0);
        stp = 1'b1;
        ev[25] = 1'b1;
        ev[21] = 1'b1;
        rdc(STS, 32'h0200_0000);
        wr(STS, 32'hFFFF_FFFF);
        cyc;
        tmr = 16'hFFFF;
        rdc(STS, 32'h0);
        tmr = 16'h0000;
        cyc;
        tmr = 16'hFFFF;
        rdc(STS, 32'h0008_0000);
        drp = 28'h7FF_FFFE;
        cyc;
        drp = 28'h800_0000;
        rdc(STS, 32'h0008_0000);
        drp = 28'h7FF_FFFF;
        cyc;
        drp = 28'h800_0000;
        rdc(STS, 32'h0088_0000);
        wr(STS, 32'hFFFF_FFFF);
        len = 16'h0800;
        ev[15] = 1'b1;
        rdc(STS, 32'h0);
        len = 16'h0801;
        ev[15] = 1'b1;
        rdc(STS, 32'h0000_8000);
        wr(STS, 32'hFFFF_FFFF);
        cnt = 12'h003;
        ev[20] = 1'b1;
        cyc;
        for (int k = 0; k < 3; k++)
        begin
            ev[22] = 1'b1;
            rdc(STS, (k == 2) ? 32'h0010_0000 : 32'h0);
        end
        wr(STS, 32'hFFFF_FFFF);
        lu = 8'h05;
        lt = 8'h05;
        rdc(STS, 32'h0);
        lu = 8'h06;
        rdc(STS, 32'h0000_0288);
        lu = 8'h00;
        wr(STS, 32'hFFFF_FFFF);
        rdc(STS, 32'h0);
        i_isc_host_model.gap = 3;
        xcv = 1'b1;
        rdc(STS, 32'h0004_0000);
        wr(STS, 32'hFFFF_FFFF);
        rdc(STS, 32'h0004_0000);
        xcv = 1'b0;
        rdc(STS, 32'h0);
        i_isc_host_model.gap = 0;
        ev[6] = 1'b1;
        rdc(STS, 32'h0000_0040);
        fork
            wr(STS, 32'h0000_0040);
            begin
                @(posedge mclk);
                #1 ev[6] = 1'b1;
                cyc;
            end
        join
        rdc(STS, 32'h0000_0040);
        wr(STS, 32'hFFFF_FFFF);
        wr(ENA, 32'hFFFF_FFFF);
        rdc(ENA, ISC_ENABLE_MASK);
        rdc(STS, 32'h8000_0000);
        ev[17] = 1'b1;
        rdc(STS, 32'h8002_0000);
        chk(power_event_irq, 1'b1);
        wr(ENA, 32'h0002_0000);
        wr(STS, 32'h8000_0000);
        chk(master_irq, 1'b1);
        wr(STS, 32'hFFFF_FFFF);
        rdc(STS, 32'h0);
        chk(master_irq, 1'b0);
        wr(ENA, 32'h0);
        wr(8'h64, 32'h0);
        chk(wake_request, 1'b1);
        cyc;
        chk(wake_request, 1'b0);
        wr(STS, 32'h0);
        chk(wake_request, 1'b0);
        ev[6] = 1'b1;
        cyc;
        rst_n = 1'b0;
        cyc;
        rst_n = 1'b1;
        rdc(STS, 32'h0);
        wrap_up;
    end
endmodule // test_interrupt_status_collector
